// File: inc/fault_supervisor_pkg.sv
// Constants for the half-bridge fault supervisor.
// Operation
// - Overvoltage on either supply rail sets the supply-fail flag, output bit 15.
// - Overvoltage with lockout enable 1 forces every driver off while it persists.
// - Overvoltage with lockout enable 0 sets the flag only, outputs stay programmed.
// - Supply faults keep stored programming; outputs resume unaided when supply recovers.
// - Supply-fail flag stays latched until a frame carries status reset 1.
// - Thermal warning sets output bit 0 and leaves outputs enabled.
// - Any of six sensors at shutdown level turns all channels off together.
// - Thermal shutdown keeps channel selection; outputs return after recovery.
// - Thermal warning flag stays latched until a status-reset frame.
// - Chip select falling with serial input 0 shows the warning flag at once.
// - Fast readout drives 0 without warning and 1 with warning latched.
// - Delay select 0: overcurrent lasting 200 us latches the driver off.
// - Delay select 1: overcurrent lasting 25 us latches driver off until reset.
// - Underload enable 1: underload of 350 us latches driver off and flag.
// - Underload enable 0: underload latches the flag only, drivers unchanged.
// - Overvoltage supply-fail clears only below hysteresis and with status reset.
// - Undervoltage sets supply-fail and forces all outputs off while it lasts.
// - Overcurrent shutdown sets the overload flag; driver stays off until reset.
// - Underload flag in output bit 14 is 1 once any channel's delay expired.
package fault_supervisor_pkg;
  localparam int unsigned NUM_CH          = 6;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned OC_LONG_US      = 200;
  localparam int unsigned OC_SHORT_US     = 25;
  localparam int unsigned UL_DELAY_US     = 350;
  localparam int unsigned OC_LONG_CYC     = OC_LONG_US * CLK_MHZ;
  localparam int unsigned OC_SHORT_CYC    = OC_SHORT_US * CLK_MHZ;
  localparam int unsigned UL_DELAY_CYC    = UL_DELAY_US * CLK_MHZ;
  localparam int unsigned TMR_W           = 16;
  localparam int unsigned FLAG_BIT_SUPPLY = 15;
  localparam int unsigned FLAG_BIT_UL     = 14;
  localparam int unsigned FLAG_BIT_OL     = 13;
  localparam int unsigned FLAG_BIT_TW     = 0;
endpackage

// File: src/half_bridge_fault_supervisor.sv
// Fault supervision, latching and output gating for the six half-bridge channels.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_fault_supervisor #(
  parameter int unsigned OC_LONG_CYCLES  = fault_supervisor_pkg::OC_LONG_CYC,
  parameter int unsigned OC_SHORT_CYCLES = fault_supervisor_pkg::OC_SHORT_CYC,
  parameter int unsigned UL_CYCLES       = fault_supervisor_pkg::UL_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic                                    clock_i,
  input  wire logic                                    rstn_i,
  // Programming and control from the frame decoder, same clock.
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] upper_switch_cmd_i,
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] lower_switch_cmd_i,
  input  wire logic                                    overvoltage_lockout_enable_i,
  input  wire logic                                    overcurrent_delay_select_i,
  input  wire logic                                    underload_shutdown_enable_i,
  input  wire logic                                    frame_valid_i,
  input  wire logic                                    status_reset_request_i,
  // Analog comparators, asynchronous.
  input  wire logic                                    overvoltage_i,
  input  wire logic                                    ov_hysteresis_i,
  input  wire logic                                    undervoltage_lockout_i,
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] thermal_warning_i,
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] thermal_shutdown_i,
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] overcurrent_i,
  input  wire logic [fault_supervisor_pkg::NUM_CH-1:0] underload_i,
  // Serial link pins, asynchronous.
  input  wire logic                                    chip_select_n_i,
  input  wire logic                                    serial_in_i,
  // Gated drivers.
  output logic [fault_supervisor_pkg::NUM_CH-1:0]      upper_switch_o,
  output logic [fault_supervisor_pkg::NUM_CH-1:0]      lower_switch_o,
  // Status.
  output logic                                         supply_fail_flag_o,
  output logic                                         thermal_warning_flag_o,
  output logic                                         overload_flag_o,
  output logic                                         underload_flag_o,
  output logic [15:0]                                  status_word_o,
  // Fast readout on the serial output.
  output logic                                         fast_readout_o,
  output logic                                         fast_readout_oe_n_o
);
  import fault_supervisor_pkg::*;

  localparam int unsigned SYN_W = 4 * NUM_CH + 5;

  logic [SYN_W-1:0] sync1_ff;
  logic [SYN_W-1:0] sync2_ff;
  logic [NUM_CH-1:0] tw_s;
  logic [NUM_CH-1:0] tsd_s;
  logic [NUM_CH-1:0] oc_s;
  logic [NUM_CH-1:0] ul_s;
  logic ov_s;
  logic hyst_s;
  logic uv_s;
  logic csn_s;
  logic si_s;

  // All asynchronous inputs form one word, so they share one two-stage synchroniser.
  logic [SYN_W-1:0] sync_in;
  assign sync_in = {underload_i, overcurrent_i, thermal_shutdown_i, thermal_warning_i,
                    overvoltage_i, ov_hysteresis_i, undervoltage_lockout_i, chip_select_n_i, serial_in_i};

  // Only the second stage is read, so a metastable first stage never reaches logic.
  always_ff @(posedge clock_i) begin
    sync1_ff <= sync_in;
    sync2_ff <= sync1_ff;
  end
  assign {ul_s, oc_s, tsd_s, tw_s, ov_s, hyst_s, uv_s, csn_s, si_s} = sync2_ff;

  // A clear request is only honoured inside a decoded frame.
  logic clr;
  assign clr = frame_valid_i & status_reset_request_i;

  // Flag state.
  logic              supply_ff;
  logic              supply_ov_ff;
  logic              tw_ff;
  logic              ol_ff;
  logic              ul_ff;
  logic [NUM_CH-1:0] oc_latch_ff;
  logic [NUM_CH-1:0] ul_latch_ff;
  logic              nxt_supply;
  logic              nxt_supply_ov;
  logic              nxt_tw;
  logic              nxt_ol;
  logic              nxt_ul;
  logic [NUM_CH-1:0] nxt_oc_latch;
  logic [NUM_CH-1:0] nxt_ul_latch;
  // Timers.
  logic [TMR_W-1:0]  ul_tmr_ff;
  logic [TMR_W-1:0]  nxt_ul_tmr;
  logic [NUM_CH-1:0] oc_expire;
  logic              ul_expire;

  // True on the edge at which a timer counting up from zero reaches its limit.
  function automatic logic timer_done(input logic [TMR_W-1:0] count, input int unsigned limit);
    logic [31:0] next_count;
    next_count = 32'(count) + 32'h0000_0001;
    if (next_count >= limit) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // Each channel owns its timer, so channels that trip together never share a count.
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_oc
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;
    logic             sel_ff;
    logic             nxt_sel;
    logic             expire;

    // Delay select is captured when the timer starts, so a later change cannot cut it short.
    always_comb begin
      nxt_tmr = '0;
      nxt_sel = overcurrent_delay_select_i;
      expire  = 1'b0;
      if (oc_s[ch] && !oc_latch_ff[ch]) begin
        nxt_sel = (tmr_ff == '0) ? overcurrent_delay_select_i : sel_ff;
        if (nxt_sel) begin
          expire = timer_done(tmr_ff, OC_SHORT_CYCLES);
        end else begin
          expire = timer_done(tmr_ff, OC_LONG_CYCLES);
        end
        nxt_tmr = expire ? '0 : tmr_ff + TMR_W'(1);
      end
    end

    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        tmr_ff <= '0;
        sel_ff <= 1'b0;
      end else begin
        tmr_ff <= nxt_tmr;
        sel_ff <= nxt_sel;
      end
    end
    assign oc_expire[ch] = expire;
  end

  // One global underload timer; later channels see the remainder of the running count.
  always_comb begin
    nxt_ul_tmr = '0;
    ul_expire  = 1'b0;
    if (|ul_s) begin
      ul_expire  = timer_done(ul_tmr_ff, UL_CYCLES);
      nxt_ul_tmr = ul_expire ? ul_tmr_ff : ul_tmr_ff + TMR_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ul_tmr_ff <= '0;
    end else begin
      ul_tmr_ff <= nxt_ul_tmr;
    end
  end

  // Sets win over a status-reset clear arriving in the same cycle, in every flag group below.
  always_comb begin
    nxt_supply_ov = (supply_ov_ff & ~(clr & hyst_s)) | ov_s;
    nxt_supply    = ((supply_ff & ~clr) | (supply_ff & supply_ov_ff & ~hyst_s)) | ov_s | uv_s;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      supply_ff    <= 1'b0;
      supply_ov_ff <= 1'b0;
    end else begin
      supply_ff    <= nxt_supply;
      supply_ov_ff <= nxt_supply_ov;
    end
  end

  // Thermal warning flag.
  always_comb begin
    nxt_tw = (tw_ff & ~clr) | (|tw_s);
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tw_ff <= 1'b0;
    end else begin
      tw_ff <= nxt_tw;
    end
  end

  // Overload flag and per-channel overcurrent latches.
  always_comb begin
    nxt_oc_latch = (oc_latch_ff & {NUM_CH{~clr}}) | oc_expire;
    nxt_ol       = (ol_ff & ~clr) | (|oc_expire);
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      oc_latch_ff <= '0;
      ol_ff       <= 1'b0;
    end else begin
      oc_latch_ff <= nxt_oc_latch;
      ol_ff       <= nxt_ol;
    end
  end

  // Underload flag and per-channel underload latches.
  always_comb begin
    nxt_ul_latch = (ul_latch_ff & {NUM_CH{~clr}})
                 | ({NUM_CH{ul_expire & underload_shutdown_enable_i}} & ul_s);
    nxt_ul       = (ul_ff & ~clr) | ul_expire;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ul_latch_ff <= '0;
      ul_ff       <= 1'b0;
    end else begin
      ul_latch_ff <= nxt_ul_latch;
      ul_ff       <= nxt_ul;
    end
  end

  // Output gating; the stored commands are never touched, so recovery from a global fault needs no new frame.
  logic              global_off;
  logic [NUM_CH-1:0] nxt_up;
  logic [NUM_CH-1:0] nxt_lo;
  logic [NUM_CH-1:0] up_ff;
  logic [NUM_CH-1:0] lo_ff;

  // Global causes act on every channel at once.
  always_comb begin
    global_off = (ov_s & overvoltage_lockout_enable_i)
               | uv_s
               | (|tsd_s);
  end

  // A latched channel stays off on its own, while a global fault darkens every channel.
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_gate
    logic chan_off;
    assign chan_off   = global_off | oc_latch_ff[ch] | ul_latch_ff[ch];
    assign nxt_up[ch] = upper_switch_cmd_i[ch] & ~chan_off;
    assign nxt_lo[ch] = lower_switch_cmd_i[ch] & ~chan_off;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      up_ff <= '0;
      lo_ff <= '0;
    end else begin
      up_ff <= nxt_up;
      lo_ff <= nxt_lo;
    end
  end

  // Fast readout: the pin follows the latched warning while chip select is low.
  logic csn_d_ff;
  logic fast_en_ff;
  logic nxt_fast_en;
  logic fast_ff;
  logic nxt_fast;

  always_comb begin
    nxt_fast_en = fast_en_ff;
    if (csn_s) begin
      nxt_fast_en = 1'b0;
    end else if (csn_d_ff && !si_s) begin
      nxt_fast_en = 1'b1;
    end
    nxt_fast = nxt_tw;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      csn_d_ff   <= 1'b1;
      fast_en_ff <= 1'b0;
      fast_ff    <= 1'b0;
    end else begin
      csn_d_ff   <= csn_s;
      fast_en_ff <= nxt_fast_en;
      fast_ff    <= nxt_fast;
    end
  end

  // Every output but fast_readout_oe_n_o, the inverted enable flop, comes straight from a flip-flop.
  assign upper_switch_o         = up_ff;
  assign lower_switch_o         = lo_ff;
  assign supply_fail_flag_o     = supply_ff;
  assign thermal_warning_flag_o = tw_ff;
  assign overload_flag_o        = ol_ff;
  assign underload_flag_o       = ul_ff;
  always_comb begin
    status_word_o                  = 16'h0000;
    status_word_o[FLAG_BIT_SUPPLY] = supply_ff;
    status_word_o[FLAG_BIT_UL]     = ul_ff;
    status_word_o[FLAG_BIT_OL]     = ol_ff;
    status_word_o[FLAG_BIT_TW]     = tw_ff;
  end
  assign fast_readout_o      = fast_ff;
  assign fast_readout_oe_n_o = ~fast_en_ff;
endmodule
`default_nettype wire

// File: verification/fault_supervisor_sva.sv
// Checker for the half-bridge fault supervisor ports.
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor_sva import fault_supervisor_pkg::*; (
  // Clock, reset and inputs.
  input wire logic              clock_i, rstn_i, frame_valid_i, status_reset_request_i,
  input wire logic              overvoltage_i, overvoltage_lockout_enable_i, undervoltage_lockout_i,
  input wire logic              chip_select_n_i, serial_in_i,
  input wire logic [NUM_CH-1:0] thermal_warning_i, thermal_shutdown_i,
  // Outputs.
  input wire logic [NUM_CH-1:0] upper_switch_o, lower_switch_o,
  input wire logic              supply_fail_flag_o, thermal_warning_flag_o, overload_flag_o,
  input wire logic              underload_flag_o, fast_readout_o, fast_readout_oe_n_o,
  input wire logic [15:0]       status_word_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Five cycles of a held cause leave room for the two-stage synchroniser.
  AST_UV_OFF: assert property (undervoltage_lockout_i [*5] |-> (upper_switch_o | lower_switch_o) == '0)
    else $error("Drivers on during undervoltage.");
  AST_PSF_SET: assert property ((overvoltage_i || undervoltage_lockout_i) [*5] |-> supply_fail_flag_o)
    else $error("Supply flag not set.");
  AST_OV_OFF: assert property ((overvoltage_i && overvoltage_lockout_enable_i) [*5] |-> (upper_switch_o | lower_switch_o) == '0)
    else $error("Drivers on during overvoltage lockout.");
  AST_TW_SET: assert property ((|thermal_warning_i) [*5] |-> thermal_warning_flag_o)
    else $error("Warning flag not set.");
  AST_TSD_OFF: assert property ((|thermal_shutdown_i) [*5] |-> (upper_switch_o | lower_switch_o) == '0)
    else $error("Drivers on during thermal shutdown.");
  AST_TW_HOLD: assert property (thermal_warning_flag_o && !(frame_valid_i && status_reset_request_i) |=> thermal_warning_flag_o)
    else $error("Warning flag dropped without reset.");
  AST_PSF_HOLD: assert property (supply_fail_flag_o && !(frame_valid_i && status_reset_request_i) |=> supply_fail_flag_o)
    else $error("Supply flag dropped without reset.");
  AST_WORD: assert property (status_word_o == {supply_fail_flag_o, underload_flag_o, overload_flag_o, 12'h000, thermal_warning_flag_o})
    else $error("Status word does not match flags.");
  AST_FAST_ON: assert property ((!chip_select_n_i && !serial_in_i) [*5] |-> !fast_readout_oe_n_o)
    else $error("Fast readout not driven.");
  AST_FAST_VAL: assert property (!fast_readout_oe_n_o && $stable(thermal_warning_flag_o) |-> fast_readout_o == thermal_warning_flag_o)
    else $error("Fast readout value wrong.");
endmodule
bind half_bridge_fault_supervisor fault_supervisor_sva SVA (.*);
`default_nettype wire

// File: verification/host_model.sv
// Host model driving chip select and serial input for the fast warning readout.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clock_i,
  input  wire logic read_req_i,
  output logic      chip_select_n_o,
  output logic      serial_in_o
);
  // Serial input idles at its pull-down level, so a falling select asks for the warning bit.
  initial serial_in_o = 1'b0;
  always @(posedge clock_i) begin
    chip_select_n_o <= #1 !read_req_i;
  end
endmodule
`default_nettype wire

// File: verification/tb_half_bridge_fault_supervisor.sv
// Self-checking bench for the half-bridge fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_half_bridge_fault_supervisor;
  localparam logic [5:0] UP = 6'h15;
  localparam logic [5:0] LO = 6'h2a;
  logic clock_i = 1'b0, rstn_i = 1'b0, read_req = 1'b0;
  logic [5:0] upper_switch_cmd_i = UP, lower_switch_cmd_i = LO;
  logic overvoltage_lockout_enable_i = 1'b0, overcurrent_delay_select_i = 1'b0, underload_shutdown_enable_i = 1'b0;
  logic frame_valid_i = 1'b0, status_reset_request_i = 1'b0;
  logic overvoltage_i = 1'b0, ov_hysteresis_i = 1'b0, undervoltage_lockout_i = 1'b0;
  logic [5:0] thermal_warning_i = '0, thermal_shutdown_i = '0, overcurrent_i = '0, underload_i = '0;
  wire logic chip_select_n_i, serial_in_i;
  logic [5:0] upper_switch_o, lower_switch_o;
  logic supply_fail_flag_o, thermal_warning_flag_o, overload_flag_o, underload_flag_o;
  logic fast_readout_o, fast_readout_oe_n_o;
  logic [15:0] status_word_o;
  int bad_count = 0;
  int n_compared = 0;
  // Short counts keep the run brief; the expectations below use the same figures.
  half_bridge_fault_supervisor #(.OC_LONG_CYCLES(40), .OC_SHORT_CYCLES(5), .UL_CYCLES(70)) DUT (.*);
  host_model HOST (.clock_i(clock_i), .read_req_i(read_req), .chip_select_n_o(chip_select_n_i),
                   .serial_in_o(serial_in_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic outs(input logic [5:0] u, input logic [5:0] l);
    chk(16'(upper_switch_o), 16'(u));
    chk(16'(lower_switch_o), 16'(l));
  endtask
  task automatic clear();
    frame_valid_i = 1'b1;
    status_reset_request_i = 1'b1;
    cyc(1);
    frame_valid_i = 1'b0;
    status_reset_request_i = 1'b0;
    cyc(1);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_ov(input logic en);
    overvoltage_lockout_enable_i = en;
    ov_hysteresis_i = 1'b0;
    overvoltage_i = 1'b1;
    cyc(5);
    chk(status_word_o, 16'h8000);
    outs(en ? 6'h00 : UP, en ? 6'h00 : LO);
    overvoltage_i = 1'b0;
    cyc(5);
    outs(UP, LO);
    clear();
    chk(16'(supply_fail_flag_o), 16'h0001);
    ov_hysteresis_i = 1'b1;
    cyc(3);
    clear();
    chk(16'(supply_fail_flag_o), 16'h0000);
  endtask
  task automatic t_uv();
    undervoltage_lockout_i = 1'b1;
    cyc(5);
    outs(6'h00, 6'h00);
    undervoltage_lockout_i = 1'b0;
    cyc(5);
    outs(UP, LO);
    chk(status_word_o, 16'h8000);
    clear();
  endtask
  task automatic t_tw();
    thermal_warning_i = 6'h20;
    cyc(5);
    chk(status_word_o, 16'h0001);
    outs(UP, LO);
    thermal_warning_i = 6'h00;
    read_req = 1'b1;
    cyc(6);
    chk(16'(thermal_warning_flag_o), 16'h0001);
    chk(16'({fast_readout_oe_n_o, fast_readout_o}), 16'h0001);
    read_req = 1'b0;
    thermal_shutdown_i = 6'h04;
    cyc(5);
    outs(6'h00, 6'h00);
    thermal_shutdown_i = 6'h00;
    cyc(5);
    outs(UP, LO);
    clear();
    read_req = 1'b1;
    cyc(6);
    chk(16'({fast_readout_oe_n_o, fast_readout_o}), 16'h0000);
    read_req = 1'b0;
    cyc(5);
  endtask
  task automatic t_oc(input logic sel, input int n);
    overcurrent_delay_select_i = sel;
    overcurrent_i = 6'h01;
    cyc(n);
    chk(16'(upper_switch_o), 16'(UP));
    cyc(6);
    overcurrent_i = 6'h00;
    cyc(5);
    outs(6'h14, LO);
    chk(status_word_o, 16'h2000);
    clear();
    cyc(3);
    outs(UP, LO);
  endtask
  task automatic t_ul(input logic en);
    underload_shutdown_enable_i = en;
    underload_i = 6'h02;
    cyc(78);
    underload_i = 6'h00;
    cyc(5);
    chk(status_word_o, 16'h4000);
    outs(UP, en ? 6'h28 : LO);
    clear();
  endtask
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #100us;
    bad_count++;
    end_sim();
  end
  initial begin
    cyc(20);
    chk(status_word_o, 16'h0000);
    rstn_i = 1'b1;
    cyc(4);
    outs(UP, LO);
    t_ov(1'b1);
    t_ov(1'b0);
    t_uv();
    t_tw();
    t_oc(1'b0, 40);
    t_oc(1'b1, 5);
    t_ul(1'b0);
    t_ul(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
